/* bench/rx_los_eq_checker.sv */
// checker: port assertions for the loss and equalizer control bank
// assumes one clock domain and binding to the bank's top module
module rx_los_eq_checker (
    input wire logic ref_clk, // clock
    input wire logic sys_rst, // async reset
    input wire logic rx_interface_bypass, // bank held in reset
    input wire logic master_quiescent_test, // master test bit
    input wire logic [7:0] reg_addr, // register address
    input wire logic reg_wr, // write strobe
    input wire logic [7:0] reg_wdata, // write data
    input wire logic rx_data_in, // data before muting
    input wire logic rx_data_out, // data after muting
    input wire logic [3:0] analog_dig_out, // gated analog outputs
    input wire logic ind_data_load, // ram word loaded
    input wire logic [7:0] eq_ram_index, // loop counter
    input wire logic [2:0] eq_loop_rate_sel, // loop rate field
    input wire logic los_state, // loss state
    input wire logic irq_n // interrupt, active low
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    logic fc_wr;
    assign fc_wr = reg_wr && reg_addr == 8'hFC && !rx_interface_bypass;
    // ----
    // no loss for two samples, and no reset in between
    // ----
    sequence s_quiet;
        !los_state ##1 !los_state && !$past(rx_interface_bypass)
            && !$past(sys_rst);
    endsequence
    a_bypass_holds: assert property (
        rx_interface_bypass |=> !los_state && irq_n
            && eq_ram_index == 8'h00 && eq_loop_rate_sel == 3'h3)
        else $error("bypass did not hold state in reset");
    a_quiet_grounds: assert property (
        master_quiescent_test |=> analog_dig_out == 4'h0)
        else $error("analog outputs not grounded");
    a_data_passes: assert property (
        s_quiet |-> rx_data_out == $past(rx_data_in))
        else $error("data muted without loss");
    a_irq_cause: assert property (
        !irq_n |-> los_state != $past(los_state)
            || $past(los_state) != $past(los_state, 2))
        else $error("interrupt without loss change");
    a_irq_pulse: assert property (
        !irq_n |=> irq_n)
        else $error("interrupt longer than one cycle");
    a_index_write: assert property (
        reg_wr && reg_addr == 8'hFE && !rx_interface_bypass
            |=> eq_ram_index == $past(reg_wdata))
        else $error("loop counter not overwritten");
    a_rate_write: assert property (
        reg_wr && reg_addr == 8'hFF && !rx_interface_bypass
            |=> eq_loop_rate_sel == $past(reg_wdata[2:0]))
        else $error("loop rate field not written");
    a_load_cause: assert property (
        ind_data_load |-> $past(fc_wr) || $past(fc_wr, 2)
            || $past(fc_wr, 3))
        else $error("ram load without address write");
    a_load_once: assert property (
        ind_data_load |=> !ind_data_load)
        else $error("ram load repeated");
endmodule : rx_los_eq_checker

bind rx_line_los_and_equalizer_ctrl rx_los_eq_checker u_chk (
    .ref_clk, .sys_rst, .rx_interface_bypass, .master_quiescent_test,
    .reg_addr, .reg_wr, .reg_wdata, .rx_data_in, .rx_data_out,
    .analog_dig_out, .ind_data_load, .eq_ram_index, .eq_loop_rate_sel,
    .los_state, .irq_n
);

/* bench/test_rx_line_los_and_equalizer_ctrl.sv */
// testbench for the receive loss and equalizer control bank
// assumes the bank alone, inputs driven at falling edges of 50 MHz
module test_rx_line_los_and_equalizer_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, sys_rst = 1'b1, rx_interface_bypass = 1'b0;
    logic master_quiescent_test = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic pulse_tick = 1'b0, e1_mode = 1'b0, rx_data_in = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    logic [7:0] cable_loss_estimate = 8'h00;
    logic [2:0] signal_level = 3'h7;
    logic [31:0] ind_data_wr = 32'h0;
    logic [3:0] analog_dig_in = 4'hF;
    logic [7:0] reg_rdata, eq_ram_index;
    logic [31:0] ind_data_rd;
    logic [3:0] analog_dig_out;
    logic [2:0] eq_loop_rate_sel;
    logic ind_data_load, rx_data_out, eq_loop_tick, los_state, irq_n;
    int failures = 0, samples_checked = 0, cycles = 0;

    rx_line_los_and_equalizer_ctrl dut (
        .ref_clk, .sys_rst, .rx_interface_bypass, .master_quiescent_test,
        .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .pulse_tick,
        .signal_level, .cable_loss_estimate, .ind_data_wr, .ind_data_rd,
        .ind_data_load, .e1_mode, .rx_data_in, .rx_data_out,
        .analog_dig_in, .analog_dig_out, .eq_ram_index, .eq_loop_rate_sel,
        .eq_loop_tick, .los_state, .irq_n
    );

    always #10 ref_clk = ~ref_clk;
    // longest run is the stability wait, about 53k cycles of 90k
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles > 90000) begin
            failures++;
            $display("[FAIL] %0t run timed out", $time);
            final_report;
        end
    end
    // ----
    // shared bus and compare tasks
    // ----
    task automatic final_report;
        if (failures == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] g, input logic [31:0] e,
                       input string s);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, s, g, e);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask : wr

    // data stands until the next read, so one spare cycle is safe
    task automatic rd(input logic [7:0] a, input logic [7:0] m,
                      input logic [7:0] e, input string s);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        @(negedge ref_clk);
        chk(reg_rdata & m, e, s);
    endtask : rd

    task automatic ticks(input int n);
        repeat (n) begin
            @(negedge ref_clk);
            pulse_tick = 1'b1;
            @(negedge ref_clk);
            pulse_tick = 1'b0;
        end
    endtask : ticks

    task automatic see_irq(input logic e);
        logic seen;
        seen = 1'b0;
        repeat (8) begin
            @(negedge ref_clk);
            if (irq_n === 1'b0) seen = 1'b1;
        end
        chk(seen, e, "irq pulse");
    endtask : see_irq

    task automatic got_load(input logic [31:0] e);
        logic seen;
        seen = 1'b0;
        repeat (4) begin
            @(negedge ref_clk);
            if (ind_data_load === 1'b1) begin
                seen = 1'b1;
                chk(ind_data_rd, e, "ram word");
            end
        end
        chk(seen, 1'b1, "ram load");
    endtask : got_load

    task automatic period(input int e);
        int n;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (eq_loop_tick !== 1'b1 && n < 9000);
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (eq_loop_tick !== 1'b1 && n < 9000);
        chk(n, e, "loop period");
    endtask : period

    task automatic loops(input int k);
        repeat (k) begin
            do begin
                @(negedge ref_clk);
            end while (eq_loop_tick !== 1'b1);
        end
    endtask : loops
    // ----
    // scenarios
    // ----
    task automatic t_reset;
        rd(8'hF8, 8'h3F, 8'h01, "cfg reset");
        rd(8'hF9, 8'hFF, 8'h00, "thr reset");
        rd(8'hFA, 8'hFF, 8'h01, "det period reset");
        rd(8'hFB, 8'hFF, 8'h01, "clr period reset");
        rd(8'hFC, 8'hFF, 8'h00, "addr reset");
        rd(8'hFD, 8'hFF, 8'h80, "dir reset");
        rd(8'hFE, 8'hFF, 8'h00, "loop reset");
        rd(8'hFF, 8'hFF, 8'h03, "eq cfg reset");
        rd(8'h10, 8'hFF, 8'h00, "unmapped");
        wr(8'hFF, 8'hFF);
        rd(8'hFF, 8'hFF, 8'hCF, "eq cfg rw");
        wr(8'hFF, 8'h08);
        chk(eq_loop_rate_sel, 3'h0, "rate sel");
    endtask : t_reset

    task automatic t_quiet;
        repeat (2) @(negedge ref_clk);
        chk(analog_dig_out, 4'hF, "analog pass");
        master_quiescent_test = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk(analog_dig_out, 4'h0, "master test");
        master_quiescent_test = 1'b0;
        wr(8'hF8, 8'h09);
        @(negedge ref_clk);
        chk(analog_dig_out, 4'h0, "local test");
        wr(8'hF8, 8'h01);
    endtask : t_quiet

    task automatic t_ram;
        wr(8'hFD, 8'h00);
        ind_data_wr = 32'hA5C3_1E77;
        wr(8'hFC, 8'h2A);
        repeat (3) @(negedge ref_clk);
        ind_data_wr = 32'h0F0F_1234;
        wr(8'hFC, 8'h2B);
        repeat (3) @(negedge ref_clk);
        ind_data_wr = 32'h0;
        wr(8'hFD, 8'h80);
        wr(8'hFC, 8'h2A);
        got_load(32'hA5C3_1E77);
        wr(8'hFC, 8'h2B);
        got_load(32'h0F0F_1234);
    endtask : t_ram

    task automatic t_loop;
        wr(8'hFE, 8'h5C);
        chk(eq_ram_index, 8'h5C, "index written");
        rd(8'hFE, 8'hFF, 8'h5C, "index read");
        cable_loss_estimate = 8'h21;
        period(2072);
        chk(eq_ram_index, 8'h21, "index follows loop");
        wr(8'hFF, 8'h09);
        period(4144);
        wr(8'hFF, 8'h08);
        e1_mode = 1'b1;
        period(1562);
        e1_mode = 1'b0;
    endtask : t_loop

    task automatic t_los;
        wr(8'hF9, 8'h33);
        wr(8'hF8, 8'h31);
        rx_data_in = 1'b1;
        signal_level = 3'h2;
        ticks(10);
        signal_level = 3'h5;
        ticks(1);
        signal_level = 3'h3;
        ticks(15);
        see_irq(1'b0);
        chk(los_state, 1'b0, "early loss");
        ticks(1);
        see_irq(1'b1);
        chk(los_state, 1'b1, "loss declared");
        chk(rx_data_out, 1'b0, "muted");
        rd(8'hF8, 8'hC0, 8'hC0, "event set");
        rd(8'hF8, 8'hC0, 8'h40, "event cleared");
        wr(8'hFB, 8'h02);
        signal_level = 3'h4;
        ticks(31);
        chk(los_state, 1'b1, "early clear");
        ticks(1);
        see_irq(1'b1);
        chk(los_state, 1'b0, "loss cleared");
        rd(8'hF8, 8'hC0, 8'h00, "no event on clear");
        chk(rx_data_out, 1'b1, "unmuted");
        wr(8'hF8, 8'h01);
        signal_level = 3'h2;
        ticks(16);
        see_irq(1'b0);
        chk(los_state, 1'b1, "loss again");
        chk(rx_data_out, 1'b1, "no mute when off");
    endtask : t_los

    task automatic t_bypass;
        wr(8'hFA, 8'h7E);
        rx_interface_bypass = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk(los_state, 1'b0, "bypass loss");
        rx_interface_bypass = 1'b0;
        rd(8'hFA, 8'hFF, 8'h01, "bypass period");
        rd(8'hF9, 8'hFF, 8'h00, "bypass thr");
    endtask : t_bypass

    // a move of more than 8 steps restarts the 32-period window
    task automatic t_stable;
        wr(8'hFF, 8'h08);
        e1_mode = 1'b1;
        cable_loss_estimate = 8'h60;
        loops(1);
        cable_loss_estimate = 8'h68; // within 8 steps
        loops(32);
        rd(8'hF8, 8'h04, 8'h00, "stable early");
        loops(1);
        rd(8'hF8, 8'h04, 8'h04, "eq stable");
    endtask : t_stable

    initial begin
        repeat (5) @(negedge ref_clk);
        sys_rst = 1'b0;
        t_reset;
        t_quiet;
        t_ram;
        t_loop;
        t_los;
        t_bypass;
        t_stable;
        final_report;
    end
endmodule : test_rx_line_los_and_equalizer_ctrl

/* common/rx_los_eq_params.svh */
// register offsets, field positions, reset values and timing counts
// assumes an 8-bit register port with 8-bit addresses in this bank
`ifndef RX_LOS_EQ_PARAMS_SVH
`define RX_LOS_EQ_PARAMS_SVH

`define LOS_CONFIG_STATUS_ADDR 8'hF8
`define LOS_THRESHOLD_SELECT_ADDR 8'hF9
`define LOS_DETECT_PERIOD_ADDR 8'hFA
`define LOS_CLEAR_PERIOD_ADDR 8'hFB
`define EQ_RAM_INDIRECT_ADDRESS_ADDR 8'hFC
`define EQ_RAM_DIRECTION_ADDR 8'hFD
`define EQ_LOOP_LOCATION_ADDR 8'hFE
`define EQ_CONFIGURATION_ADDR 8'hFF

`define CFG_EVENT_BIT 7
`define CFG_STATE_BIT 6
`define CFG_IRQ_EN_BIT 5
`define CFG_MUTE_EN_BIT 4
`define CFG_QTEST_BIT 3
`define CFG_STABLE_BIT 2
`define CFG_RESERVED_BIT 0
`define DIR_READ_BIT 7

`define CFG_RESET 8'h01
`define THR_RESET 8'h00
`define PERIOD_RESET 8'h01
`define DIR_RESET 1'b1
`define EQCFG_RESET 8'h03
`define LOOP_RESET 8'h00

// eq stability window: 2 dB equals 8 ram-table steps
`define EQ_STABLE_STEPS 8'h08
// equalizer loop base: 50 MHz / 24.125 kHz, truncated
`define REF_CLK_HZ 50000000
`define EQ_BASE_HZ 24125
`define EQ_BASE_DIV (`REF_CLK_HZ / `EQ_BASE_HZ)
// E1 loop base: 50 MHz / 32 kHz, truncated
`define EQ_E1_BASE_HZ 32000
`define EQ_E1_BASE_DIV (`REF_CLK_HZ / `EQ_E1_BASE_HZ)
`define RAM_WORDS 256

`endif

/* common/rx_los_eq_pkg.sv */
// types shared by the receive line loss and equalizer control block
// assumes nothing beyond a SystemVerilog compiler
package rx_los_eq_pkg;
    typedef enum logic [1:0] {
        RAM_IDLE = 2'b00,
        RAM_READ = 2'b01,
        RAM_WRITE = 2'b10
    } ram_op_e;
    typedef logic [31:0] ram_word_t;
endpackage : rx_los_eq_pkg

/* rtl/los_run_counter.sv */
// counts consecutive qualifying pulse intervals against 16 x period
// assumes pulse_tick marks one pulse interval of the line
module los_run_counter (
    input wire logic ref_clk, // system clock
    input wire logic sys_rst, // async reset, active high
    input wire logic hold, // synchronous hold in reset
    input wire logic pulse_tick, // one pulse interval elapsed
    input wire logic condition, // level meets the test this interval
    input wire logic [7:0] period, // duration in units of 16 intervals
    output logic reached // run length has been met
);
    logic [11:0] run;
    logic [11:0] target;

    assign target = {period, 4'h0};

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            run <= 12'h000;
        end else if (hold) begin
            run <= 12'h000;
        end else if (pulse_tick) begin
            if (!condition) begin
                run <= 12'h000;
            end else if (run != 12'hFFF) begin
                run <= run + 12'h001;
            end
        end
    end

    // zero period never qualifies
    assign reached = (target != 12'h000) && (run >= target);
endmodule : los_run_counter

/* rtl/rx_line_los_and_equalizer_ctrl.sv */
// register bank and control for receive loss of signal and equalizer
// assumes an 8-bit register port synchronous to ref_clk; the analog
// receiver supplies a level code, a cable loss estimate and ram data
`include "rx_los_eq_params.svh"

module rx_line_los_and_equalizer_ctrl
    import rx_los_eq_pkg::*;
(
    input wire logic ref_clk, // 50 MHz system clock
    input wire logic sys_rst, // async reset, active high
    input wire logic rx_interface_bypass, // holds this bank in reset
    input wire logic master_quiescent_test, // master test quiescent bit
    input wire logic [7:0] reg_addr, // register address
    input wire logic reg_wr, // one-cycle write strobe
    input wire logic reg_rd, // one-cycle read strobe
    input wire logic [7:0] reg_wdata, // write data
    output logic [7:0] reg_rdata, // read data, valid after reg_rd
    input wire logic pulse_tick, // one line pulse interval elapsed
    input wire logic [2:0] signal_level, // measured level, threshold code
    input wire logic [7:0] cable_loss_estimate, // equalizer ram step
    input wire logic [31:0] ind_data_wr, // indirect data registers
    output logic [31:0] ind_data_rd, // ram word loaded on a read
    output logic ind_data_load, // pulse: ind_data_rd is new
    input wire logic e1_mode, // E1 loop rates when high
    input wire logic rx_data_in, // recovered receive data
    output logic rx_data_out, // data after muting
    input wire logic [3:0] analog_dig_in, // analog receiver digital outs
    output logic [3:0] analog_dig_out, // gated analog outputs
    output logic [7:0] eq_ram_index, // loop read address counter
    output logic [2:0] eq_loop_rate_sel, // feedback frequency field
    output logic eq_loop_tick, // pulse at equalizer loop rate
    output logic los_state, // loss of signal state
    output logic irq_n // interrupt, active low
);
    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic hold;
    logic wr_cfg, wr_thr, wr_det, wr_clr, wr_addr, wr_dir, wr_loop, wr_eq;
    logic los_event_flag, los_irq_enable, data_mute_enable;
    logic rx_quiescent_test_enable, cfg_reserved;
    logic eq_stable;
    logic [2:0] detect_threshold, clear_threshold;
    logic [7:0] detect_period, clear_period;
    logic [7:0] ind_addr;
    logic ram_dir_read;
    logic [1:0] valid_per;
    logic eq_reserved;
    logic [7:0] next_rdata;
    logic det_reached, clr_reached;
    logic los_change;

    assign hold = rx_interface_bypass;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = reg_wr && (a == r);
    endfunction : hit

    assign wr_cfg = hit(reg_addr, `LOS_CONFIG_STATUS_ADDR);
    assign wr_thr = hit(reg_addr, `LOS_THRESHOLD_SELECT_ADDR);
    assign wr_det = hit(reg_addr, `LOS_DETECT_PERIOD_ADDR);
    assign wr_clr = hit(reg_addr, `LOS_CLEAR_PERIOD_ADDR);
    assign wr_addr = hit(reg_addr, `EQ_RAM_INDIRECT_ADDRESS_ADDR);
    assign wr_dir = hit(reg_addr, `EQ_RAM_DIRECTION_ADDR);
    assign wr_loop = hit(reg_addr, `EQ_LOOP_LOCATION_ADDR);
    assign wr_eq = hit(reg_addr, `EQ_CONFIGURATION_ADDR);

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            los_irq_enable <= 1'b0;
            data_mute_enable <= 1'b0;
            rx_quiescent_test_enable <= 1'b0;
            cfg_reserved <= 1'b1;
        end else if (hold) begin
            los_irq_enable <= 1'b0;
            data_mute_enable <= 1'b0;
            rx_quiescent_test_enable <= 1'b0;
            cfg_reserved <= 1'b1;
        end else if (wr_cfg) begin
            los_irq_enable <= reg_wdata[`CFG_IRQ_EN_BIT];
            data_mute_enable <= reg_wdata[`CFG_MUTE_EN_BIT];
            rx_quiescent_test_enable <= reg_wdata[`CFG_QTEST_BIT];
            cfg_reserved <= reg_wdata[`CFG_RESERVED_BIT];
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            detect_threshold <= 3'h0;
            clear_threshold <= 3'h0;
            detect_period <= `PERIOD_RESET;
            clear_period <= `PERIOD_RESET;
        end else if (hold) begin
            detect_threshold <= 3'h0;
            clear_threshold <= 3'h0;
            detect_period <= `PERIOD_RESET;
            clear_period <= `PERIOD_RESET;
        end else begin
            if (wr_thr) begin
                detect_threshold <= reg_wdata[2:0];
                clear_threshold <= reg_wdata[6:4];
            end
            if (wr_det) begin
                detect_period <= reg_wdata;
            end
            if (wr_clr) begin
                clear_period <= reg_wdata;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ind_addr <= 8'h00;
            ram_dir_read <= `DIR_RESET;
            valid_per <= 2'h0;
            eq_reserved <= 1'b0;
            eq_loop_rate_sel <= 3'h3;
        end else if (hold) begin
            ind_addr <= 8'h00;
            ram_dir_read <= `DIR_RESET;
            valid_per <= 2'h0;
            eq_reserved <= 1'b0;
            eq_loop_rate_sel <= 3'h3;
        end else begin
            if (wr_addr) begin
                ind_addr <= reg_wdata;
            end
            if (wr_dir) begin
                ram_dir_read <= reg_wdata[`DIR_READ_BIT];
            end
            if (wr_eq) begin
                valid_per <= reg_wdata[7:6];
                eq_reserved <= reg_wdata[3];
                eq_loop_rate_sel <= reg_wdata[2:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // register read; reading the status register clears the event flag
    // ------------------------------------------------------------------
    always_comb begin
        next_rdata = 8'h00;
        case (reg_addr)
            `LOS_CONFIG_STATUS_ADDR: begin
                next_rdata = {los_event_flag, los_state, los_irq_enable,
                    data_mute_enable, rx_quiescent_test_enable,
                    eq_stable, 1'b0, cfg_reserved};
            end
            `LOS_THRESHOLD_SELECT_ADDR: begin
                next_rdata = {1'b0, clear_threshold, 1'b0, detect_threshold};
            end
            `LOS_DETECT_PERIOD_ADDR: next_rdata = detect_period;
            `LOS_CLEAR_PERIOD_ADDR: next_rdata = clear_period;
            `EQ_RAM_INDIRECT_ADDRESS_ADDR: next_rdata = ind_addr;
            `EQ_RAM_DIRECTION_ADDR: next_rdata = {ram_dir_read, 7'h00};
            `EQ_LOOP_LOCATION_ADDR: next_rdata = eq_ram_index;
            `EQ_CONFIGURATION_ADDR: begin
                next_rdata = {valid_per, 2'b00, eq_reserved,
                    eq_loop_rate_sel};
            end
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // loss of signal detection and clearance
    // ------------------------------------------------------------------
    // codes are ordered by level, so compare the codes directly; code
    // 000 never detects and 111 never clears
    los_run_counter u_detect (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .hold(hold || los_state),
        .pulse_tick(pulse_tick),
        .condition((detect_threshold != 3'h0)
            && (signal_level <= detect_threshold)),
        .period(detect_period),
        .reached(det_reached)
    );

    los_run_counter u_clear (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .hold(hold || !los_state),
        .pulse_tick(pulse_tick),
        .condition((clear_threshold != 3'h7)
            && (signal_level >= clear_threshold)),
        .period(clear_period),
        .reached(clr_reached)
    );

    assign los_change = (!los_state && det_reached)
        || (los_state && clr_reached);

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            los_state <= 1'b0;
        end else if (hold) begin
            los_state <= 1'b0;
        end else if (!los_state && det_reached) begin
            los_state <= 1'b1;
        end else if (los_state && clr_reached) begin
            los_state <= 1'b0;
        end
    end

    // set wins over the clearing read
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            los_event_flag <= 1'b0;
        end else if (hold) begin
            los_event_flag <= 1'b0;
        end else if (!los_state && det_reached) begin
            los_event_flag <= 1'b1;
        end else if (reg_rd && reg_addr == `LOS_CONFIG_STATUS_ADDR) begin
            los_event_flag <= 1'b0;
        end
    end

    // low pulse one cycle per change of state
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_n <= 1'b1;
        end else begin
            irq_n <= !(los_change && los_irq_enable && !hold);
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_data_out <= 1'b0;
            analog_dig_out <= 4'h0;
        end else begin
            rx_data_out <= rx_data_in && !(data_mute_enable && los_state);
            if (rx_quiescent_test_enable || master_quiescent_test) begin
                analog_dig_out <= 4'h0;
            end else begin
                analog_dig_out <= analog_dig_in;
            end
        end
    end

    // ------------------------------------------------------------------
    // equalizer loop rate, loop counter and stability
    // ------------------------------------------------------------------
    // each mode has its own base rate, divided by n+1
    logic [15:0] div_cnt;
    logic [15:0] div_top;
    always_comb begin
        div_top = 16'((e1_mode ? `EQ_E1_BASE_DIV : `EQ_BASE_DIV)
            * (32'(eq_loop_rate_sel) + 32'd1));
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_cnt <= 16'h0000;
            eq_loop_tick <= 1'b0;
        end else if (hold || div_cnt >= div_top - 16'h0001) begin
            div_cnt <= 16'h0000;
            eq_loop_tick <= !hold;
        end else begin
            div_cnt <= div_cnt + 16'h0001;
            eq_loop_tick <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            eq_ram_index <= `LOOP_RESET;
        end else if (hold) begin
            eq_ram_index <= `LOOP_RESET;
        end else if (wr_loop) begin
            eq_ram_index <= reg_wdata;
        end else if (eq_loop_tick) begin
            eq_ram_index <= cable_loss_estimate;
        end
    end

    // reference loss and count of stable loop periods
    logic [7:0] ref_loss;
    logic [8:0] stable_cnt;
    logic [8:0] stable_need;
    logic [7:0] loss_diff;
    assign stable_need = 9'(9'd32 << valid_per);
    assign loss_diff = (cable_loss_estimate >= ref_loss)
        ? cable_loss_estimate - ref_loss : ref_loss - cable_loss_estimate;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ref_loss <= 8'h00;
            stable_cnt <= 9'h000;
            eq_stable <= 1'b0;
        end else if (hold) begin
            ref_loss <= 8'h00;
            stable_cnt <= 9'h000;
            eq_stable <= 1'b0;
        end else if (eq_loop_tick) begin
            if (loss_diff > `EQ_STABLE_STEPS) begin
                ref_loss <= cable_loss_estimate;
                stable_cnt <= 9'h000;
                eq_stable <= 1'b0;
            end else if (stable_cnt >= stable_need) begin
                eq_stable <= 1'b1;
            end else begin
                stable_cnt <= stable_cnt + 9'h001;
            end
        end
    end

    // ------------------------------------------------------------------
    // equalizer ram, indirect access
    // ------------------------------------------------------------------
    ram_word_t eq_ram [`RAM_WORDS];
    ram_op_e ram_op;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ram_op <= RAM_IDLE;
        end else if (hold) begin
            ram_op <= RAM_IDLE;
        end else if (wr_addr) begin
            ram_op <= ram_dir_read ? RAM_READ : RAM_WRITE;
        end else begin
            ram_op <= RAM_IDLE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (ram_op == RAM_WRITE) begin
            eq_ram[ind_addr] <= ind_data_wr;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ind_data_rd <= 32'h00000000;
            ind_data_load <= 1'b0;
        end else begin
            case (ram_op)
                RAM_READ: begin
                    ind_data_rd <= eq_ram[ind_addr];
                    ind_data_load <= 1'b1;
                end
                default: ind_data_load <= 1'b0;
            endcase
        end
    end
endmodule : rx_line_los_and_equalizer_ctrl
